/* src/wburst_ctrl.sv */
/*
 * controller end: apb registers, link clock divider, command spacing and write data
 * assumes an apb master on clk and the memory end on the link interface
 */
// Local design decisions: the address map and the APB slave port.
`timescale 1ns/1ps
module wburst_ctrl #(
	parameter int DEPTH = 80
) (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        resetn,
	// apb slave
	input  wire logic [7:0]  paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// link
	wburst_link_if.ctrl      link
);
	typedef struct packed {
		logic [2:0]           div;
		logic                 ck;
		logic                 pend;
		logic [2:0]           p_cmd;
		logic [7:0]           p_ctl;
		logic [15:0]          addr;
		logic [19:0]          cfg;
		logic [19:0]          tim;
		logic [15:0]          wdata;
		logic [2:0]           cmd;
		logic [1:0]           bg;
		logic [1:0]           ba;
		logic [15:0]          laddr;
		logic [15:0]          dq;
		logic [5:0]           ccd;
		logic [5:0]           wr_cnt;
		logic [5:0]           wtr_s;
		logic [5:0]           wtr_l;
		logic [1:0]           last_bg;
		logic                 bact;
		logic [2:0]           bidx;
		wburst_pkg::slot_t    bslot;
		logic [15:0]          acc;
		logic                 pready;
		logic                 pslverr;
		logic [31:0]          prdata;
	} ctl_state_t;
	ctl_state_t st_reg, st_next;

	logic                 fall;
	logic                 issue;
	logic                 ok;
	logic                 is_wr;
	logic                 occ;
	logic                 data_bus_inversion;
	logic [1:0]           p_bg;
	logic [6:0]           wl;
	wburst_pkg::slot_t    head;
	wburst_pkg::slot_t    new_slot;

	// saturating down count of a timer
	function automatic logic [5:0] dec(logic [5:0] x);
		return (x == 6'h00) ? 6'h00 : x - 6'h01;
	endfunction

	// one timing field widened for a timer
	function automatic logic [5:0] fld(logic [19:0] w, int lsb);
		return {1'b0, w[lsb +: 5]};
	endfunction

	assign fall  = st_reg.ck && (st_reg.div == wburst_pkg::CK_HALF_CYC);
	assign data_bus_inversion   = st_reg.cfg[wburst_pkg::F_DBI];
	assign p_bg  = st_reg.p_ctl[2:1];
	assign is_wr = (st_reg.p_cmd == wburst_pkg::CMD_WR) || (st_reg.p_cmd == wburst_pkg::CMD_WRA);
	assign wl    = wburst_pkg::write_lat(st_reg.cfg[wburst_pkg::F_AL +: 5], st_reg.cfg[wburst_pkg::F_CWL +: 5],
		st_reg.cfg[wburst_pkg::F_PAR]);
	assign new_slot = wburst_pkg::make_slot(st_reg.cfg[wburst_pkg::F_BURST +: 2], st_reg.p_ctl[0],
		st_reg.cfg[wburst_pkg::F_CRC], st_reg.p_cmd == wburst_pkg::CMD_WRA);

	// timers read one or less once the interval has run out
	always_comb begin
		unique case (st_reg.p_cmd)
			wburst_pkg::CMD_WR, wburst_pkg::CMD_WRA:
				ok = st_reg.ccd <= 6'h01;
			wburst_pkg::CMD_RD:
				ok = !occ && !st_reg.bact && ((p_bg == st_reg.last_bg) ? st_reg.wtr_l <= 6'h01
					: st_reg.wtr_s <= 6'h01);
			wburst_pkg::CMD_PRE:
				ok = !occ && !st_reg.bact && st_reg.wr_cnt <= 6'h01;
			wburst_pkg::CMD_MRS:
				ok = !occ && !st_reg.bact;
			default:
				ok = 1'b1;
		endcase
	end
	assign issue = fall && st_reg.pend && ok;

	// write bursts wait out the write latency here
	wburst_sched #(
		.W     (wburst_pkg::SLOT_W),
		.DEPTH (DEPTH)
	) u_sched (
		.clk    (clk),
		.resetn (resetn),
		.shift  (fall),
		.ins    (issue && is_wr),
		.pos    (wl - 7'h01), // head is taken on the step after it arrives
		.din    (new_slot),
		.head   (head),
		.occ    (occ)
	);

	// next-state logic
	always_comb begin
		logic [2:0] dclk;
		dclk = 3'h0;
		st_next         = st_reg;
		st_next.pready  = 1'b0;
		st_next.pslverr = 1'b0;
		// link clock divider
		if (st_reg.div == wburst_pkg::CK_HALF_CYC) begin
			st_next.div = 3'h0;
			st_next.ck  = !st_reg.ck;
		end else begin
			st_next.div = st_reg.div + 3'h1;
		end
		if (fall) begin
			st_next.ccd    = dec(st_reg.ccd);
			st_next.wr_cnt = dec(st_reg.wr_cnt);
			st_next.wtr_s  = dec(st_reg.wtr_s);
			st_next.wtr_l  = dec(st_reg.wtr_l);
			// burst end: load recovery timers from the reference point
			if (st_reg.bact && st_reg.bidx == st_reg.bslot.nclk - 3'h1) begin
				st_next.bact   = 1'b0;
				st_next.wr_cnt = data_bus_inversion ? fld(st_reg.tim, wburst_pkg::T_WRDBI)
					: fld(st_reg.cfg, wburst_pkg::F_WR);
				st_next.wtr_s  = fld(st_reg.tim, data_bus_inversion ? wburst_pkg::T_WTRDBI : wburst_pkg::T_WTRS);
				st_next.wtr_l  = fld(st_reg.tim, data_bus_inversion ? wburst_pkg::T_WTRDBI : wburst_pkg::T_WTRL);
			end
			if (head.nclk != 3'h0) begin
				st_next.bact  = 1'b1;
				st_next.bidx  = 3'h0;
				st_next.bslot = head;
				st_next.acc   = 16'h0000;
			end else if (st_reg.bact && st_next.bact) begin
				st_next.bidx = st_reg.bidx + 3'h1;
			end
			// data clocks carry a counting pattern, then the crc word
			dclk       = st_next.bslot.chop ? wburst_pkg::CHOP_DATA_CLKS : wburst_pkg::BURST_CLKS;
			st_next.dq = 16'h0000;
			if (st_next.bact && st_next.bidx < dclk) begin
				st_next.dq  = st_reg.wdata + {13'h0000, st_next.bidx};
				st_next.acc = st_next.acc ^ st_next.dq;
			end else if (st_next.bact && st_next.bslot.crc && st_next.bidx == dclk) begin
				st_next.dq = st_next.acc;
			end
			// command slot: deselect unless something is due
			st_next.cmd   = wburst_pkg::CMD_DES;
			st_next.laddr = 16'h0000;
			if (issue) begin
				st_next.pend  = 1'b0;
				st_next.cmd   = st_reg.p_cmd;
				st_next.bg    = p_bg;
				st_next.ba    = st_reg.p_ctl[4:3];
				st_next.laddr = st_reg.addr;
				st_next.laddr[wburst_pkg::CHOP_ADDR_BIT] = st_reg.p_ctl[0];
				if (st_reg.p_cmd == wburst_pkg::CMD_MRS) begin
					st_next.laddr = {6'h00, p_bg[0] ? st_reg.cfg[19:10] : st_reg.cfg[9:0]};
				end
				if (is_wr) begin
					st_next.ccd     = st_reg.cfg[wburst_pkg::F_CRC] ? wburst_pkg::CCD_CRC_CLKS
						: wburst_pkg::CCD_CLKS;
					st_next.last_bg = p_bg;
				end
			end
		end
		// apb access: answer one cycle into the access phase, held off while a ctrl write meets a pending command
		if (psel && penable && !st_reg.pready) begin
			if (!(pwrite && paddr == wburst_pkg::REG_CTRL && st_reg.pend)) begin
				st_next.pready = 1'b1;
				st_next.prdata = 32'h00000000;
				unique case (paddr)
					wburst_pkg::REG_CTRL:   st_next.prdata = {20'h00000, st_reg.pend, st_reg.p_ctl, st_reg.p_cmd};
					wburst_pkg::REG_ADDR:   st_next.prdata = {16'h0000, st_reg.addr};
					wburst_pkg::REG_CFG:    st_next.prdata = {12'h000, st_reg.cfg};
					wburst_pkg::REG_TIME:   st_next.prdata = {12'h000, st_reg.tim};
					wburst_pkg::REG_WDATA:  st_next.prdata = {16'h0000, st_reg.wdata};
					wburst_pkg::REG_STATUS: st_next.prdata = {27'h0000000, st_reg.wtr_l != 6'h00,
						st_reg.wr_cnt != 6'h00, st_reg.bact, occ, st_reg.pend};
					default:                st_next.pslverr = 1'b1;
				endcase
			end
		end
		// writes take effect on the edge that sees pready high
		if (psel && penable && st_reg.pready && pwrite && !st_reg.pslverr) begin
			unique case (paddr)
				wburst_pkg::REG_CTRL: begin
					st_next.pend  = 1'b1;
					st_next.p_cmd = pwdata[2:0];
					st_next.p_ctl = pwdata[10:3];
				end
				wburst_pkg::REG_ADDR:  st_next.addr  = pwdata[15:0];
				wburst_pkg::REG_CFG:   st_next.cfg   = pwdata[19:0];
				wburst_pkg::REG_TIME:  st_next.tim   = pwdata[19:0];
				wburst_pkg::REG_WDATA: st_next.wdata = pwdata[15:0];
				default:               st_next.pend  = st_next.pend;
			endcase
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			st_reg     <= '0;
			st_reg.cfg <= wburst_pkg::CFG_RST;
			st_reg.tim <= wburst_pkg::TIME_RST;
		end else begin
			st_reg <= st_next;
		end
	end

	// outputs straight from state
	assign prdata    = st_reg.prdata;
	assign pready    = st_reg.pready;
	assign pslverr   = st_reg.pslverr;
	assign link.ck   = st_reg.ck;
	assign link.cmd  = st_reg.cmd;
	assign link.bg   = st_reg.bg;
	assign link.ba   = st_reg.ba;
	assign link.addr = st_reg.laddr;
	assign link.dq   = st_reg.dq;
endmodule

/* src/wburst_pkg.sv */
/*
 * shared constants, types and decoding for the write-burst link
 * assumes both ends run on one 125 MHz clk and share these encodings
 */
package wburst_pkg;
	// link commands
	localparam logic [2:0] CMD_DES = 3'h0;
	localparam logic [2:0] CMD_WR  = 3'h1;
	localparam logic [2:0] CMD_WRA = 3'h2;
	localparam logic [2:0] CMD_RD  = 3'h3;
	localparam logic [2:0] CMD_PRE = 3'h4;
	localparam logic [2:0] CMD_MRS = 3'h5;
	// burst field codes of the burst config mode register
	localparam logic [1:0] BURST_FIX8   = 2'h0;
	localparam logic [1:0] BURST_OTF    = 2'h1;
	localparam logic [1:0] BURST_FIXBC4 = 2'h2;
	localparam int CHOP_ADDR_BIT = 12;
	// config word fields (mode0 = bits 9:0, mode1 = bits 19:10)
	localparam int F_BURST = 0;
	localparam int F_DBI   = 2;
	localparam int F_PAR   = 3;
	localparam int F_CRC   = 4;
	localparam int F_WR    = 5;
	localparam int F_CWL   = 10;
	localparam int F_AL    = 15;
	localparam int M1_CWL  = 0;
	localparam int M1_AL   = 5;
	// timing word fields
	localparam int T_WTRS   = 0;
	localparam int T_WTRL   = 5;
	localparam int T_WTRDBI = 10;
	localparam int T_WRDBI  = 15;
	// reset values
	localparam logic [19:0] CFG_RST  = 20'h02580;
	localparam logic [19:0] TIME_RST = 20'h69cc2;
	localparam logic [9:0]  M0_RST   = 10'h180;
	localparam logic [9:0]  M1_RST   = 10'h009;
	// burst timing in link clocks
	localparam logic [6:0] PARITY_LAT      = 7'h04;
	localparam logic [2:0] BURST_CLKS      = 3'h4;
	localparam logic [2:0] CHOP_FIXED_CLKS = 3'h2;
	localparam logic [2:0] CHOP_DATA_CLKS  = 3'h2;
	localparam logic [5:0] CCD_CLKS        = 6'h04;
	localparam logic [5:0] CCD_CRC_CLKS    = 6'h05;
	// link clock divider
	localparam int CLK_PERIOD_NS = 8;
	localparam int CK_PERIOD_NS  = 64;
	localparam logic [2:0] CK_HALF_CYC = 3'(CK_PERIOD_NS / CLK_PERIOD_NS / 2 - 1);
	// apb register offsets
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_ADDR   = 8'h04;
	localparam logic [7:0] REG_CFG    = 8'h08;
	localparam logic [7:0] REG_TIME   = 8'h0c;
	localparam logic [7:0] REG_WDATA  = 8'h10;
	localparam logic [7:0] REG_STATUS = 8'h14;

	typedef struct packed {
		logic       ap;
		logic       crc;
		logic       chop;
		logic [2:0] nclk;
	} slot_t;
	localparam int SLOT_W = 6;

	// burst shape of one write from mode and chop bit
	function automatic slot_t make_slot(logic [1:0] burst, logic chop_bit, logic crc, logic ap);
		slot_t s;
		s.ap   = ap;
		s.crc  = crc;
		s.chop = (burst == BURST_FIXBC4) || (burst == BURST_OTF && !chop_bit);
		s.nclk = ((burst == BURST_FIXBC4) ? CHOP_FIXED_CLKS : BURST_CLKS) + {2'h0, crc};
		return s;
	endfunction

	// write latency in link clocks
	function automatic logic [6:0] write_lat(logic [4:0] al, logic [4:0] write_column_latency, logic par);
		return {2'h0, al} + {2'h0, write_column_latency} + (par ? PARITY_LAT : 7'h00);
	endfunction
endpackage

/* src/wburst_link_if.sv */
/*
 * command and data wires between controller and memory device
 * assumes the controller drives every wire and changes them on the falling link clock
 */
`timescale 1ns/1ps
interface wburst_link_if;
	logic        ck;
	logic [2:0]  cmd;
	logic [1:0]  bg;
	logic [1:0]  ba;
	logic [15:0] addr;
	logic [15:0] dq;
	modport ctrl (output ck, output cmd, output bg, output ba, output addr, output dq);
	modport dev (input ck, input cmd, input bg, input ba, input addr, input dq);
endinterface

/* src/wburst_sched.sv */
/*
 * delay line that releases a burst slot a given number of steps after insertion
 * assumes insertion position stays below DEPTH
 */
`timescale 1ns/1ps
module wburst_sched #(
	parameter int W     = 6,
	parameter int DEPTH = 80
) (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         resetn,
	// control
	input  wire logic         shift,
	input  wire logic         ins,
	input  wire logic [6:0]   pos,
	input  wire logic [W-1:0] din,
	// results
	output logic      [W-1:0] head,
	output logic              occ
);
	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] line;
	} sched_state_t;
	sched_state_t st_reg, st_next;

	// shift toward the head, then drop the new slot at its position
	always_comb begin
		st_next = st_reg;
		if (shift) begin
			for (int i = 0; i < DEPTH - 1; i++) begin
				st_next.line[i] = st_reg.line[i + 1];
			end
			st_next.line[DEPTH - 1] = '0;
		end
		if (ins) begin
			st_next.line[pos] = din;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign head = st_reg.line[0];
	assign occ  = |st_reg.line;
endmodule

/* src/wburst_dev.sv */
/*
 * memory-side end: samples the link, shapes write bursts, marks reference points
 * assumes the controller keeps link spacing and recovery intervals
 */
`timescale 1ns/1ps
module wburst_dev #(
	parameter int DEPTH = 80
) (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        resetn,
	// link
	wburst_link_if.dev       link,
	// user side
	output logic      [15:0] wdata,
	output logic             wdata_valid,
	output logic             burst_ref,
	output logic             ap_done,
	output logic             crc_err,
	output logic      [3:0]  burst_beats
);
	typedef struct packed {
		logic [39:0]          s1;
		logic [39:0]          s2;
		logic [39:0]          s3;
		logic                 ckl;
		logic [9:0]           mode0;
		logic [9:0]           mode1;
		logic                 bact;
		logic [2:0]           bidx;
		wburst_pkg::slot_t    bslot;
		logic [15:0]          acc;
		logic [5:0]           apc;
		logic [15:0]          wdata;
		logic                 wvalid;
		logic                 ref_p;
		logic                 apdone;
		logic                 crc_err;
		logic [3:0]           beats;
	} dev_state_t;
	dev_state_t st_reg, st_next;

	logic                 tick;
	logic [2:0]           s_cmd;
	logic [1:0]           s_bg;
	logic [15:0]          s_addr;
	logic [15:0]          s_dq;
	logic                 is_wr;
	wburst_pkg::slot_t    head;
	wburst_pkg::slot_t    new_slot;
	logic [6:0]           wl;

	// settled link values and rising link edge
	assign s_cmd  = st_reg.s3[38:36];
	assign s_bg   = st_reg.s3[35:34];
	assign s_addr = st_reg.s3[31:16];
	assign s_dq   = st_reg.s3[15:0];
	assign tick   = (st_reg.s2[39] == st_reg.s3[39]) && st_reg.s3[39] && !st_reg.ckl;
	assign is_wr  = tick && (s_cmd == wburst_pkg::CMD_WR || s_cmd == wburst_pkg::CMD_WRA);
	assign wl     = wburst_pkg::write_lat(st_reg.mode1[wburst_pkg::M1_AL +: 5], st_reg.mode1[wburst_pkg::M1_CWL +: 5],
		st_reg.mode0[wburst_pkg::F_PAR]);
	assign new_slot = wburst_pkg::make_slot(st_reg.mode0[wburst_pkg::F_BURST +: 2], s_addr[wburst_pkg::CHOP_ADDR_BIT],
		st_reg.mode0[wburst_pkg::F_CRC], s_cmd == wburst_pkg::CMD_WRA);

	// burst slots wait out the write latency here
	wburst_sched #(
		.W     (wburst_pkg::SLOT_W),
		.DEPTH (DEPTH)
	) u_sched (
		.clk    (clk),
		.resetn (resetn),
		.shift  (tick),
		.ins    (is_wr),
		.pos    (wl - 7'h01), // head is taken on the tick after it arrives
		.din    (new_slot),
		.head   (head),
		.occ    ()
	);

	// next-state logic
	always_comb begin
		logic [2:0] dclk;
		dclk = 3'h0;
		st_next        = st_reg;
		st_next.s1     = {link.ck, link.cmd, link.bg, link.ba, link.addr, link.dq};
		st_next.s2     = st_reg.s1;
		st_next.s3     = st_reg.s2;
		st_next.wvalid = 1'b0;
		st_next.ref_p  = 1'b0;
		st_next.apdone = 1'b0;
		if (st_reg.s2[39] == st_reg.s3[39]) begin
			st_next.ckl = st_reg.s3[39];
		end
		if (tick) begin
			// reference point is the edge after the last burst clock
			if (st_reg.bact && st_reg.bidx == st_reg.bslot.nclk - 3'h1) begin
				st_next.ref_p = 1'b1;
				st_next.bact  = 1'b0;
				if (st_reg.bslot.ap) begin
					st_next.apc = {1'b0, st_reg.mode0[wburst_pkg::F_WR +: 5]};
				end
			end else if (st_reg.apc != 6'h00) begin
				st_next.apc    = st_reg.apc - 6'h01;
				st_next.apdone = (st_reg.apc == 6'h01);
			end
			if (head.nclk != 3'h0) begin
				st_next.bact  = 1'b1;
				st_next.bidx  = 3'h0;
				st_next.bslot = head;
				st_next.acc   = 16'h0000;
				st_next.beats = head.chop ? 4'h4 : 4'h8;
			end else if (st_reg.bact && st_next.bact) begin
				st_next.bidx = st_reg.bidx + 3'h1;
			end
			// capture data clocks, then check the crc clock
			dclk = st_next.bslot.chop ? wburst_pkg::CHOP_DATA_CLKS : wburst_pkg::BURST_CLKS;
			if (st_next.bact && st_next.bidx < dclk) begin
				st_next.wdata  = s_dq;
				st_next.wvalid = 1'b1;
				st_next.acc    = st_next.acc ^ s_dq;
			end else if (st_next.bact && st_next.bslot.crc && st_next.bidx == dclk) begin
				st_next.crc_err = st_reg.crc_err | (s_dq != st_next.acc);
			end
			// mode register loads
			if (s_cmd == wburst_pkg::CMD_MRS) begin
				if (s_bg[0]) begin
					st_next.mode1 = s_addr[9:0];
				end else begin
					st_next.mode0 = s_addr[9:0];
				end
			end
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			st_reg       <= '0;
			st_reg.mode0 <= wburst_pkg::M0_RST;
			st_reg.mode1 <= wburst_pkg::M1_RST;
		end else begin
			st_reg <= st_next;
		end
	end

	// outputs straight from state
	assign wdata       = st_reg.wdata;
	assign wdata_valid = st_reg.wvalid;
	assign burst_ref   = st_reg.ref_p;
	assign ap_done     = st_reg.apdone;
	assign crc_err     = st_reg.crc_err;
	assign burst_beats = st_reg.beats;
endmodule

/* bench/wburst_link_asserts.sv */
/*
 * checker on the link wires between controller and memory end
 * assumes one clk domain and bench settings no shorter than cwl 9, wr 12, wtr 2
 */
`timescale 1ns/1ps
module wburst_link_asserts (
	// clock and reset
	input wire logic        clk,
	input wire logic        resetn,
	// link wires
	input wire logic        ck,
	input wire logic [2:0]  cmd,
	input wire logic [15:0] dq
);
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	logic [9:0] since_reg;
	logic       is_wr;
	logic       cmd_new;

	// a new command is anything but deselect, and goes out at a falling link clock
	assign is_wr   = (cmd == wburst_pkg::CMD_WR) || (cmd == wburst_pkg::CMD_WRA);
	assign cmd_new = (cmd != wburst_pkg::CMD_DES);

	// clk cycles since the last write command, saturating
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			since_reg <= 10'h3ff;
		end else if ($fell(ck) && is_wr) begin
			since_reg <= 10'h000;
		end else if (since_reg != 10'h3ff) begin
			since_reg <= since_reg + 10'h001;
		end
	end

	a_ck_high_phase: assert property ($rose(ck) |-> ck[*4] ##1 !ck) else $error("link clock high phase wrong");
	a_cmd_on_fall: assert property ($changed(cmd) |-> $fell(ck)) else $error("command moved off falling edge");
	a_dq_on_fall: assert property ($changed(dq) |-> $fell(ck)) else $error("data moved off falling edge");
	a_cmd_held: assert property ($changed(cmd) |=> $stable(cmd)[*7]) else $error("command not held one period");
	a_wr_spacing: assert property (($fell(ck) && is_wr) |-> since_reg >= 10'h01f) else $error("writes too close");
	a_pre_recovery: assert property (($fell(ck) && cmd == wburst_pkg::CMD_PRE) |-> since_reg >= 10'h0b7)
		else $error("precharge before recovery");
	a_rd_turnaround: assert property (($fell(ck) && cmd == wburst_pkg::CMD_RD) |-> since_reg >= 10'h067)
		else $error("read before turnaround");
	a_mrs_quiet: assert property (($fell(ck) && cmd == wburst_pkg::CMD_MRS) |-> since_reg >= 10'h04f)
		else $error("mode set during write data");
	c_cmd_seen: cover property ($fell(ck) && cmd_new);
endmodule

/* bench/test_ddr4_write_burst_turnaround.sv */
/*
 * bench for controller and memory end joined by the link interface
 * assumes apb master on clk, 4-cycle reset, expectations from default timing fields
 */
`timescale 1ns/1ps
module test_ddr4_write_burst_turnaround;
	typedef struct {logic [19:0] cfg; logic chop; int beats; int words; int span; int wl;} row_t;
	typedef struct {logic [19:0] cfg; logic [2:0] c; logic [1:0] bg; int gap;} turn_t;
	logic        clk;
	logic        resetn;
	logic [7:0]  paddr;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [15:0] wdata;
	logic        wdata_valid;
	logic        burst_ref;
	logic        ap_done;
	logic        crc_err;
	logic [3:0]  burst_beats;
	logic [15:0] w0;
	logic [31:0] rd;
	logic        err;
	logic        ck_q = 1'b0;
	int          n_fail = 0;
	int          n_compared = 0;
	int          cyc = 0;
	int          nw = 0;
	int          t_wr = 0;
	int          t_wr_prev = 0;
	int          t_oth = 0;
	int          t_first = 0;
	int          t_ref = 0;
	int          t_ap = 0;
	row_t        rows[7] = '{'{20'h02580, 1'b0, 8, 4, 4, 9}, '{20'h02581, 1'b0, 4, 2, 4, 9},
		'{20'h02581, 1'b1, 8, 4, 4, 9}, '{20'h02582, 1'b1, 4, 2, 2, 9}, '{20'h02590, 1'b0, 8, 4, 5, 9},
		'{20'h02588, 1'b0, 8, 4, 4, 13}, '{20'h12580, 1'b0, 8, 4, 4, 11}};
	turn_t       turns[5] = '{'{20'h02580, wburst_pkg::CMD_PRE, 2'h0, 200}, '{20'h02580, wburst_pkg::CMD_RD, 2'h1, 120},
		'{20'h02580, wburst_pkg::CMD_RD, 2'h0, 152}, '{20'h02584, wburst_pkg::CMD_RD, 2'h1, 160},
		'{20'h02584, wburst_pkg::CMD_PRE, 2'h0, 208}};

	wburst_link_if link ();
	wburst_ctrl i_wburst_ctrl (.clk(clk), .resetn(resetn), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link.ctrl));
	wburst_dev i_wburst_dev (.clk(clk), .resetn(resetn), .link(link.dev), .wdata(wdata), .wdata_valid(wdata_valid),
		.burst_ref(burst_ref), .ap_done(ap_done), .crc_err(crc_err), .burst_beats(burst_beats));
	wburst_link_asserts i_wburst_link_asserts (.clk(clk), .resetn(resetn), .ck(link.ck), .cmd(link.cmd), .dq(link.dq));

	// clock generator
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// timestamps of link commands and memory-side pulses
	always @(posedge clk) begin
		cyc++;
		if (ck_q && !link.ck && link.cmd != wburst_pkg::CMD_DES) begin
			if (link.cmd == wburst_pkg::CMD_WR || link.cmd == wburst_pkg::CMD_WRA) begin
				t_wr_prev = t_wr;
				t_wr = cyc;
			end else begin
				t_oth = cyc;
			end
		end
		ck_q = link.ck;
		if (wdata_valid === 1'b1) begin
			if (nw == 0) begin
				t_first = cyc;
				w0 = wdata;
			end
			nw++;
		end
		if (burst_ref === 1'b1) t_ref = cyc;
		if (ap_done === 1'b1) t_ap = cyc;
	end

	// one apb transfer; holds the request until pready is sampled
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do
			@(posedge clk);
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask

	task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// poll status until nothing pending, in flight or recovering
	task idle;
		do
			apb(1'b0, wburst_pkg::REG_STATUS, 32'h0);
		while (rd[4:0] !== 5'h00);
		repeat (16) @(posedge clk);
	endtask

	// same burst mode in controller and memory end
	task setcfg(input logic [19:0] c);
		apb(1'b1, wburst_pkg::REG_CFG, {12'h000, c});
		apb(1'b1, wburst_pkg::REG_ADDR, {22'h0, c[9:0]});
		apb(1'b1, wburst_pkg::REG_CTRL, {29'h0, wburst_pkg::CMD_MRS});
		apb(1'b1, wburst_pkg::REG_CTRL, {26'h0, 2'h1, 1'b0, wburst_pkg::CMD_MRS});
		idle;
	endtask

	task issue(input logic [2:0] c, input logic chop, input logic [1:0] bg);
		apb(1'b1, wburst_pkg::REG_CTRL, {26'h0, bg, chop, c});
	endtask

	task wrap_up;
		$display("compared %0d mismatches %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// hang guard
	initial begin
		repeat (40000) @(posedge clk);
		n_fail++;
		wrap_up;
	end

	// main sequence
	initial begin
		resetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		repeat (4) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		apb(1'b1, wburst_pkg::REG_WDATA, 32'h00001234);
		foreach (rows[i]) begin
			setcfg(rows[i].cfg);
			nw = 0;
			issue(wburst_pkg::CMD_WR, rows[i].chop, 2'h0);
			idle;
			chk("beats", {28'h0, burst_beats}, rows[i].beats);
			chk("words", nw, rows[i].words);
			chk("first word", {16'h0, w0}, 32'h00001234);
			chk("latency", (t_first - t_wr - 4) / 8, rows[i].wl);
			chk("burst end", t_ref - t_first, rows[i].span * 8);
		end
		// back-to-back chop then full burst to another bank group
		setcfg(20'h02581);
		issue(wburst_pkg::CMD_WR, 1'b0, 2'h0);
		issue(wburst_pkg::CMD_WR, 1'b1, 2'h1);
		idle;
		chk("write spacing", t_wr - t_wr_prev, 32);
		chk("mixed beats", {28'h0, burst_beats}, 8);
		// crc writes back to back need the longer spacing
		setcfg(20'h02591);
		issue(wburst_pkg::CMD_WR, 1'b0, 2'h0);
		issue(wburst_pkg::CMD_WR, 1'b1, 2'h0);
		idle;
		chk("crc spacing", t_wr - t_wr_prev, 40);
		foreach (turns[i]) begin
			setcfg(turns[i].cfg);
			issue(wburst_pkg::CMD_WR, 1'b1, 2'h0);
			issue(turns[i].c, 1'b0, turns[i].bg);
			idle;
			chk("turnaround", t_oth - t_wr, turns[i].gap);
		end
		setcfg(20'h02580);
		issue(wburst_pkg::CMD_WRA, 1'b1, 2'h0);
		idle;
		chk("auto precharge", t_ap - t_ref, 96);
		chk("crc flag", {31'h0, crc_err}, 0);
		apb(1'b0, 8'h18, 32'h0);
		chk("unmapped error", {31'h0, err}, 1);
		chk("unmapped data", rd, 0);
		// second reset in mid-run
		resetn <= 1'b0;
		repeat (4) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		apb(1'b0, wburst_pkg::REG_CFG, 32'h0);
		chk("cfg reset", rd, 32'h00002580);
		apb(1'b0, wburst_pkg::REG_TIME, 32'h0);
		chk("time reset", rd, 32'h00069cc2);
		issue(wburst_pkg::CMD_WR, 1'b0, 2'h0);
		idle;
		chk("reset beats", {28'h0, burst_beats}, 8);
		wrap_up;
	end
endmodule
